// file: src/pird_dispatch.sv
// inbound request, message and completion dispatch for one root port
`timescale 1ns/1ns
module pird_dispatch
    import pird_pkg::*;
#(
    parameter int ADDR_W = PIRD_ADDR_W,
    parameter int TAG_W = PIRD_TAG_W
)(
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    input wire pird_kind_t in_kind,
    input wire logic [ADDR_W-1:0] in_addr,
    input wire logic [1:0] in_intx,
    input wire logic in_vendor_drop,
    input wire logic [1:0] in_cpl_src,
    input wire logic in_addr_is_mem,
    input wire logic in_addr_is_peer,
    input wire logic turn_off_sent,
    input wire logic tlp_pending,
    input wire logic link_idle_pin,
    input wire logic attn_enable,
    input wire logic [1:0] attn_notify_sel,
    input wire logic slot_attn_clear,
    input wire logic other_ports_gen_evt,
    output logic fwd_valid,
    output pird_dst_t fwd_dst,
    output logic [ADDR_W-1:0] fwd_addr,
    output logic [3:0] intx_wire,
    output logic err_cor_irq,
    output logic err_nonfatal_irq,
    output logic err_fatal_irq,
    output logic power_event_output_pin,
    output logic turn_off_outstanding,
    output logic tlp_block,
    output logic request_ack,
    output logic slot_status_attn,
    output logic attn_msi,
    output logic hotplug_event_wire,
    output logic attn_intx,
    output logic gen_event_wire,
    output logic barrier_pulse,
    output logic unsupported_request_error_flag,
    output logic credit_return
);
    // ----------------------------------------
    // link idle pin synchroniser
    // ----------------------------------------
    logic link_idle;
    pird_pin_sync u_idle_sync (
        .clk(clk),
        .rstn(rstn),
        .pin(link_idle_pin),
        .level(link_idle)
    );

    // ----------------------------------------
    // dispatch decode
    // ----------------------------------------
    logic next_fwd_valid;
    pird_dst_t next_fwd_dst;
    logic [ADDR_W-1:0] next_fwd_addr;
    logic next_credit;
    logic next_barrier;
    logic next_ur;
    logic next_cor, next_nonfatal, next_fatal, next_pme;
    logic [3:0] next_intx;
    logic next_gen_own;
    logic gen_own;
    logic next_gen_wire;
    pird_dst_t peer_or_sbl;

    always_comb begin
        peer_or_sbl = in_addr_is_peer ? PIRD_DST_PEER : PIRD_DST_SBL;
        next_fwd_valid = 1'b0;
        next_fwd_dst = PIRD_DST_NONE;
        next_fwd_addr = fwd_addr;
        next_credit = 1'b0;
        next_barrier = 1'b0;
        next_ur = unsupported_request_error_flag;
        next_cor = 1'b0;
        next_nonfatal = 1'b0;
        next_fatal = 1'b0;
        next_pme = 1'b0;
        next_intx = intx_wire;
        next_gen_own = gen_own;
        if (in_valid) begin
            next_credit = 1'b1;
            next_fwd_addr = in_addr;
            case (in_kind)
                PIRD_MEM_WR, PIRD_MEM_RD: begin
                    next_fwd_valid = 1'b1;
                    next_fwd_dst = in_addr_is_mem ? PIRD_DST_MEM : peer_or_sbl;
                end
                PIRD_IO_WR, PIRD_IO_RD: begin
                    next_fwd_valid = 1'b1;
                    next_fwd_dst = peer_or_sbl;
                end
                PIRD_CFG_WR, PIRD_CFG_RD: begin
                    next_fwd_valid = 1'b1;
                    next_fwd_dst = peer_or_sbl;
                end
                PIRD_INT_SET: next_intx[in_intx] = 1'b1;
                PIRD_INT_CLR: next_intx[in_intx] = 1'b0;
                PIRD_ERR_COR: next_cor = 1'b1;
                PIRD_ERR_NONFATAL: next_nonfatal = 1'b1;
                PIRD_ERR_FATAL: next_fatal = 1'b1;
                PIRD_PM_EVENT: next_pme = 1'b1;
                PIRD_GEN_EVT_SET: next_gen_own = 1'b1;
                PIRD_GEN_EVT_CLR: next_gen_own = 1'b0;
                PIRD_BARRIER: next_barrier = 1'b1;
                PIRD_CPL: begin
                    // only non-posted requests ever see a completion
                    next_fwd_valid = 1'b1;
                    case (in_cpl_src)
                        PIRD_REQ_SRC_PEER: next_fwd_dst = PIRD_DST_PEER;
                        PIRD_REQ_SRC_SBL: next_fwd_dst = PIRD_DST_SBL;
                        default: next_fwd_dst = PIRD_DST_CPU;
                    endcase
                end
                PIRD_TURN_OFF_ACK, PIRD_ENTER_L1, PIRD_ENTER_L23, PIRD_ATTN_BUTTON: begin
                end
                default: begin
                    // vendor type 1 is dropped silently, the rest logs an error
                    if (!in_vendor_drop) begin
                        next_ur = 1'b1;
                    end
                end
            endcase
        end
        next_gen_wire = next_gen_own | other_ports_gen_evt;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            fwd_valid <= 1'b0;
            fwd_dst <= PIRD_DST_NONE;
            fwd_addr <= '0;
            credit_return <= 1'b0;
            barrier_pulse <= 1'b0;
            unsupported_request_error_flag <= 1'b0;
            err_cor_irq <= 1'b0;
            err_nonfatal_irq <= 1'b0;
            err_fatal_irq <= 1'b0;
            power_event_output_pin <= 1'b0;
            intx_wire <= PIRD_INT_RESET;
            gen_own <= 1'b0;
            gen_event_wire <= 1'b0;
        end else begin
            fwd_valid <= next_fwd_valid;
            fwd_dst <= next_fwd_dst;
            fwd_addr <= next_fwd_addr;
            credit_return <= next_credit;
            barrier_pulse <= next_barrier;
            unsupported_request_error_flag <= next_ur;
            err_cor_irq <= next_cor;
            err_nonfatal_irq <= next_nonfatal;
            err_fatal_irq <= next_fatal;
            power_event_output_pin <= next_pme;
            intx_wire <= next_intx;
            gen_own <= next_gen_own;
            gen_event_wire <= next_gen_wire;
        end
    end

    // ----------------------------------------
    // turn-off tracking and hot-plug attention
    // ----------------------------------------
    logic next_turn_off;
    logic next_slot_attn;
    logic next_msi, next_hpe, next_aintx;
    logic attn_seen;

    always_comb begin
        attn_seen = in_valid && (in_kind == PIRD_ATTN_BUTTON);
        // a new turn-off wins over an ack in the same cycle
        next_turn_off = turn_off_outstanding;
        if (in_valid && in_kind == PIRD_TURN_OFF_ACK) begin
            next_turn_off = 1'b0;
        end
        if (turn_off_sent) begin
            next_turn_off = 1'b1;
        end
        // set wins over software clear
        next_slot_attn = (slot_status_attn & ~slot_attn_clear) | attn_seen;
        next_msi = attn_seen && attn_enable && (attn_notify_sel == 2'h0);
        next_hpe = attn_seen && attn_enable && (attn_notify_sel == 2'h1);
        next_aintx = attn_seen && attn_enable && (attn_notify_sel[1] == 1'b1);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            turn_off_outstanding <= 1'b0;
            slot_status_attn <= 1'b0;
            attn_msi <= 1'b0;
            hotplug_event_wire <= 1'b0;
            attn_intx <= 1'b0;
        end else begin
            turn_off_outstanding <= next_turn_off;
            slot_status_attn <= next_slot_attn;
            attn_msi <= next_msi;
            hotplug_event_wire <= next_hpe;
            attn_intx <= next_aintx;
        end
    end

    // ----------------------------------------
    // link power entry handshake
    // ----------------------------------------
    pird_pm_t pm_state, next_pm_state;
    logic next_block, next_ack;

    always_comb begin
        next_pm_state = pm_state;
        case (pm_state)
            PIRD_PM_RUN: begin
                if (in_valid && (in_kind == PIRD_ENTER_L1 || in_kind == PIRD_ENTER_L23)) begin
                    next_pm_state = PIRD_PM_DRAIN;
                end
            end
            PIRD_PM_DRAIN: begin
                if (!tlp_pending) begin
                    next_pm_state = PIRD_PM_ACK;
                end
            end
            PIRD_PM_ACK: begin
                // idle link ends the repeated acknowledge
                if (link_idle) begin
                    next_pm_state = PIRD_PM_RUN;
                end
            end
            default: next_pm_state = PIRD_PM_RUN;
        endcase
        next_block = (next_pm_state != PIRD_PM_RUN);
        next_ack = (next_pm_state == PIRD_PM_ACK);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pm_state <= PIRD_PM_RUN;
            tlp_block <= 1'b0;
            request_ack <= 1'b0;
        end else begin
            pm_state <= next_pm_state;
            tlp_block <= next_block;
            request_ack <= next_ack;
        end
    end
endmodule

// file: src/pird_pkg.sv
// package of constants and types for the inbound request dispatch block
package pird_pkg;
    // ----------------------------------------
    // packet classes
    // ----------------------------------------
    typedef enum logic [4:0] {
        PIRD_MEM_WR = 5'h00, PIRD_MEM_RD = 5'h01, PIRD_IO_WR = 5'h02, PIRD_IO_RD = 5'h03,
        PIRD_CFG_WR = 5'h04, PIRD_CFG_RD = 5'h05, PIRD_INT_SET = 5'h06, PIRD_INT_CLR = 5'h07,
        PIRD_ERR_COR = 5'h08, PIRD_ERR_NONFATAL = 5'h09, PIRD_ERR_FATAL = 5'h0A,
        PIRD_PM_EVENT = 5'h0B, PIRD_TURN_OFF_ACK = 5'h0C, PIRD_ENTER_L1 = 5'h0D,
        PIRD_ENTER_L23 = 5'h0E, PIRD_ATTN_BUTTON = 5'h0F, PIRD_GEN_EVT_SET = 5'h10,
        PIRD_GEN_EVT_CLR = 5'h11, PIRD_BARRIER = 5'h12, PIRD_CPL = 5'h13
    } pird_kind_t;
    // ----------------------------------------
    // destinations
    // ----------------------------------------
    typedef enum logic [2:0] {
        PIRD_DST_NONE = 3'h0, PIRD_DST_MEM = 3'h1, PIRD_DST_PEER = 3'h2,
        PIRD_DST_SBL = 3'h3, PIRD_DST_CPU = 3'h4
    } pird_dst_t;
    // ----------------------------------------
    // power state machine, gray from RUN through DRAIN to ACK, not on the return to RUN
    // ----------------------------------------
    typedef enum logic [1:0] {
        PIRD_PM_RUN = 2'b00, PIRD_PM_DRAIN = 2'b01, PIRD_PM_ACK = 2'b11
    } pird_pm_t;
    localparam logic [1:0] PIRD_REQ_SRC_PEER = 2'h1;
    localparam logic [1:0] PIRD_REQ_SRC_SBL = 2'h2;
    localparam logic [3:0] PIRD_INT_RESET = 4'h0;
    localparam int PIRD_ADDR_W = 64;
    localparam int PIRD_TAG_W = 8;
    localparam int PIRD_SYNC_STAGES = 3;
endpackage

// file: src/pird_pin_sync.sv
// three-stage pin synchroniser with agreement check
`timescale 1ns/1ns
module pird_pin_sync
    import pird_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic pin,
    output logic level
);
    logic [PIRD_SYNC_STAGES-1:0] stage;
    logic [PIRD_SYNC_STAGES-1:0] next_stage;
    logic next_level;

    always_comb begin
        next_stage = {stage[PIRD_SYNC_STAGES-2:0], pin};
        // first stage feeds only the second; change counts once stages two and three agree
        next_level = (stage[1] == stage[2]) ? stage[2] : level;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            stage <= '0;
            level <= 1'b0;
        end else begin
            stage <= next_stage;
            level <= next_level;
        end
    end
endmodule

// file: dv/pird_dispatch_asserts.sv
// port checks for the inbound dispatch block
`timescale 1ns/1ns
module pird_dispatch_asserts
    import pird_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    input wire pird_kind_t in_kind,
    input wire logic in_addr_is_mem,
    input wire logic tlp_pending,
    input wire logic link_idle_pin,
    input wire logic fwd_valid,
    input wire pird_dst_t fwd_dst,
    input wire logic power_event_output_pin,
    input wire logic tlp_block,
    input wire logic request_ack,
    input wire logic slot_status_attn,
    input wire logic unsupported_request_error_flag,
    input wire logic credit_return
);
    // ----------------
    // port relations
    // ----------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_mem_route: assert property (
        in_valid && in_kind == PIRD_MEM_WR && in_addr_is_mem
        |=> fwd_valid && fwd_dst == PIRD_DST_MEM) else $error("memory write misrouted");
    chk_io_no_mem: assert property (
        in_valid && (in_kind == PIRD_IO_WR || in_kind == PIRD_IO_RD)
        |=> fwd_valid && fwd_dst != PIRD_DST_MEM) else $error("io request misrouted");
    chk_pme_pin: assert property (
        in_valid && in_kind == PIRD_PM_EVENT |=> power_event_output_pin) else $error("no pme");
    chk_block_entry: assert property (
        in_valid && (in_kind == PIRD_ENTER_L1 || in_kind == PIRD_ENTER_L23) && !tlp_block
        |=> tlp_block) else $error("entry not blocking");
    chk_ack_cause: assert property (
        $rose(request_ack) |-> tlp_block && !$past(tlp_pending)) else $error("early ack");
    // idle passes a synchroniser, so a low pin always holds the ack one more cycle
    chk_ack_hold: assert property (
        request_ack && !link_idle_pin |=> request_ack) else $error("ack dropped early");
    chk_attn_flag: assert property (
        in_valid && in_kind == PIRD_ATTN_BUTTON
        |=> slot_status_attn && !fwd_valid) else $error("attention not consumed");
    chk_unsup_sticky: assert property (
        unsupported_request_error_flag |=> unsupported_request_error_flag)
        else $error("unsupported flag lost");
    chk_unsup_credit: assert property (
        in_valid && in_kind > PIRD_CPL |=> credit_return && !fwd_valid)
        else $error("unsupported not dropped");
endmodule
bind pird_dispatch pird_dispatch_asserts i_pird_dispatch_asserts (.clk, .rstn, .in_valid,
    .in_kind, .in_addr_is_mem, .tlp_pending, .link_idle_pin, .fwd_valid, .fwd_dst,
    .power_event_output_pin, .tlp_block, .request_ack, .slot_status_attn,
    .unsupported_request_error_flag, .credit_return);

// file: dv/pird_far_end.sv
// far-side component: drains unacked packets, then idles the link
`timescale 1ns/1ns
module pird_far_end (
    input wire logic clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic tlp_block,
    input wire logic request_ack,
    output logic tlp_pending,
    output logic link_idle_pin
);
    // ----------------
    // drain and idle
    // ----------------
    logic blk_q;
    logic [3:0] drain;
    logic [1:0] idle_cnt;
    // packets in flight when blocking starts still await their acks
    assign tlp_pending = (drain != 4'h0) || (tlp_block && !blk_q);
    always @(posedge clk) begin
        blk_q <= tlp_block;
        if (!rstn) begin
            blk_q <= 1'b0;
            drain <= 4'h0;
            idle_cnt <= 2'h0;
            link_idle_pin <= 1'b0;
        end else begin
            if (tlp_block && !blk_q) drain <= slow ? 4'h6 : 4'h1;
            else if (drain != 4'h0) drain <= drain - 4'h1;
            if (!tlp_block) begin
                idle_cnt <= 2'h0;
                link_idle_pin <= 1'b0;
            end else if (request_ack && idle_cnt != 2'h3) idle_cnt <= idle_cnt + 2'h1;
            else if (idle_cnt == 2'h3) link_idle_pin <= 1'b1;
        end
    end
endmodule

// file: dv/pird_dispatch_tb.sv
// self-checking bench of the inbound dispatch block
`timescale 1ns/1ns
module pird_dispatch_tb;
    import pird_pkg::*;
    logic clk = 0, rstn = 0, in_valid = 0, in_vendor_drop = 0, in_addr_is_mem = 0;
    logic in_addr_is_peer = 0, turn_off_sent = 0, attn_enable = 0, slot_attn_clear = 0;
    logic other_ports_gen_evt = 0, slow = 0, tlp_pending, link_idle_pin;
    logic [1:0] in_intx = 2'h0, in_cpl_src = 2'h0, attn_notify_sel = 2'h0;
    logic [63:0] in_addr = 64'h0, fwd_addr;
    pird_kind_t in_kind = PIRD_MEM_WR;
    pird_dst_t fwd_dst;
    logic fwd_valid, err_cor_irq, err_nonfatal_irq, err_fatal_irq, power_event_output_pin;
    logic turn_off_outstanding, tlp_block, request_ack, slot_status_attn, attn_msi;
    logic hotplug_event_wire, attn_intx, gen_event_wire, barrier_pulse, credit_return;
    logic unsupported_request_error_flag;
    logic [3:0] intx_wire;
    int n_mismatch = 0, total_checks = 0;
    always #50 clk = ~clk;
    pird_dispatch i_pird_dispatch (.clk, .rstn, .in_valid, .in_kind, .in_addr, .in_intx,
        .in_vendor_drop, .in_cpl_src, .in_addr_is_mem, .in_addr_is_peer, .turn_off_sent,
        .tlp_pending, .link_idle_pin, .attn_enable, .attn_notify_sel, .slot_attn_clear,
        .other_ports_gen_evt, .fwd_valid, .fwd_dst, .fwd_addr, .intx_wire, .err_cor_irq,
        .err_nonfatal_irq, .err_fatal_irq, .power_event_output_pin, .turn_off_outstanding,
        .tlp_block, .request_ack, .slot_status_attn, .attn_msi, .hotplug_event_wire,
        .attn_intx, .gen_event_wire, .barrier_pulse, .unsupported_request_error_flag,
        .credit_return);
    pird_far_end i_pird_far_end (.clk, .rstn, .slow, .tlp_block, .request_ack,
        .tlp_pending, .link_idle_pin);
    // ----------------
    // scenarios
    // ----------------
    task automatic chk(input string what, input logic [63:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic pkt(input pird_kind_t k, input logic m = 0, p = 0);
        @(negedge clk);
        in_valid = 1;
        in_kind = k;
        in_addr_is_mem = m;
        in_addr_is_peer = p;
        @(negedge clk);
        in_valid = 0;
    endtask
    task automatic pulse_in(ref logic s);
        @(negedge clk);
        s = 1;
        @(negedge clk);
        s = 0;
    endtask
    task automatic wait_ack(input logic want);
        int n;
        n = 0;
        while (request_ack !== want && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (request_ack !== want) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    task automatic t_route;
        pird_dst_t e;
        for (int k = 0; k < 6; k++) begin
            for (int d = 0; d < 3; d++) begin
                e = (d == 0 && k < 2) ? PIRD_DST_MEM : (d == 1) ? PIRD_DST_PEER : PIRD_DST_SBL;
                in_addr = {56'h12_3456_789A_BC00, 8'(k * 4 + d)};
                pkt(pird_kind_t'(k), d == 0, d == 1);
                chk("dst", {fwd_valid, fwd_dst}, {1'b1, e});
                chk("addr", fwd_addr, in_addr);
            end
        end
        for (int s = 0; s < 3; s++) begin
            in_cpl_src = 2'(s);
            pkt(PIRD_CPL);
            e = (s == 1) ? PIRD_DST_PEER : (s == 2) ? PIRD_DST_SBL : PIRD_DST_CPU;
            chk("cpl", {fwd_valid, 3'(fwd_dst)}, {1'b1, 3'(e)});
        end
    endtask
    task automatic t_events;
        pird_kind_t ev[5] = '{PIRD_ERR_COR, PIRD_ERR_NONFATAL, PIRD_ERR_FATAL,
            PIRD_PM_EVENT, PIRD_BARRIER};
        for (int i = 0; i < 5; i++) begin
            pkt(ev[i]);
            chk("event", {err_cor_irq, err_nonfatal_irq, err_fatal_irq, power_event_output_pin,
                barrier_pulse, fwd_valid}, 6'h20 >> i);
        end
        // four wires held together, then released one by one
        for (int i = 0; i < 4; i++) begin
            in_intx = 2'(i);
            pkt(PIRD_INT_SET);
            chk("intx", intx_wire, (5'h02 << i) - 5'h01);
        end
        for (int i = 0; i < 4; i++) begin
            in_intx = 2'(i);
            pkt(PIRD_INT_CLR);
            chk("intx", intx_wire, (8'h0F << (i + 1)) & 8'h0F);
        end
        pulse_in(turn_off_sent);
        chk("to", turn_off_outstanding, 1);
        pkt(PIRD_TURN_OFF_ACK);
        chk("to", turn_off_outstanding, 0);
        pkt(PIRD_GEN_EVT_SET);
        chk("gpe", gen_event_wire, 1);
        pkt(PIRD_GEN_EVT_CLR);
        chk("gpe", gen_event_wire, 0);
        other_ports_gen_evt = 1;
        pulse_in(slot_attn_clear);
        chk("gpe", gen_event_wire, 1);
        other_ports_gen_evt = 0;
    endtask
    task automatic t_attn;
        attn_enable = 1;
        for (int s = 0; s < 3; s++) begin
            attn_notify_sel = 2'(s);
            pkt(PIRD_ATTN_BUTTON);
            chk("attn", {slot_status_attn, fwd_valid, attn_msi, hotplug_event_wire,
                attn_intx}, {2'b10, 3'h4 >> s});
            pulse_in(slot_attn_clear);
            chk("attn", slot_status_attn, 0);
        end
        // enables off: flag still set, no notification
        attn_enable = 0;
        pkt(PIRD_ATTN_BUTTON);
        chk("attn", {slot_status_attn, attn_msi, hotplug_event_wire, attn_intx}, 4'h8);
    endtask
    task automatic t_unsup;
        in_vendor_drop = 1;
        pkt(pird_kind_t'(5'h1E));
        chk("vd", {unsupported_request_error_flag, credit_return, fwd_valid}, 3'b010);
        in_vendor_drop = 0;
        pkt(pird_kind_t'(5'h1F));
        chk("ur", {unsupported_request_error_flag, credit_return, fwd_valid}, 3'b110);
    endtask
    task automatic t_pm(input pird_kind_t k, input logic s);
        slow = s;
        pkt(k);
        chk("block", {tlp_block, request_ack}, 2'b10);
        wait_ack(1);
        chk("drained", {tlp_block, tlp_pending}, 2'b10);
        wait_ack(0);
        chk("idle", link_idle_pin, 1);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rstn = 1;
        t_route();
        t_events();
        t_attn();
        t_unsup();
        t_pm(PIRD_ENTER_L1, 0);
        t_pm(PIRD_ENTER_L23, 1);
        complete_run();
    end
endmodule
